// File: fieldbus_adapter_pkg.sv
// Constants and carrier types of the field-bus adapter register map.
// Assumes one 40 MHz clock and 16-bit holding registers by register number.
`default_nettype none
package fieldbus_adapter_pkg;
  // ----------------------------------------
  // Region bases and lengths, in registers
  // ----------------------------------------
  localparam logic [15:0] PROD_BASE = 16'h0001;
  localparam logic [15:0] PROD_LEN = 16'h0400;
  localparam logic [15:0] CONS_BASE = 16'h0401;
  localparam logic [15:0] CONS_LEN = 16'h0400;
  localparam logic [15:0] CTRL_BASE = 16'h0801;
  localparam logic [15:0] CTRL_LEN = 16'h0100;
  localparam logic [15:0] STAT_BASE = 16'h0901;
  localparam logic [15:0] STAT_LEN = 16'h0350;
  localparam logic [15:0] REGY_BASE = 16'h0C51;
  localparam logic [15:0] REGY_LEN = 16'h1000;
  localparam logic [15:0] SCNL_BASE = 16'h1C51;
  localparam logic [15:0] SCNL_LEN = 16'h0100;
  localparam logic [15:0] CONF_BASE = 16'h1D51;
  localparam logic [15:0] CONF_LEN = 16'h0100;
  localparam logic [15:0] COPY_BASE = 16'h1E51;
  localparam logic [15:0] COPY_LEN = 16'h1000;
  localparam logic [15:0] SFR_BASE = 16'h2E51;
  localparam logic [15:0] SFR_LEN = 16'h1000;
  // ----------------------------------------
  // Registers, field positions, reset values
  // ----------------------------------------
  localparam logic [15:0] COMBINED_SCAN_CONTROL = 16'h0401;
  localparam logic [15:0] CHANNEL_ONE_SCAN_CONTROL = 16'h0801;
  localparam logic [15:0] CHANNEL_TWO_SCAN_CONTROL = 16'h0802;
  localparam logic [15:0] LINK_LOSS_TIMEOUT = 16'h1D66;
  localparam int COMB_ONE_BIT = 0;
  localparam int COMB_TWO_BIT = 7;
  localparam int CHAN_SCAN_BIT = 0;
  localparam logic SCAN_RST = 1'b0;
  localparam logic [15:0] TIMEOUT_RST = 16'h0000;
  localparam int MEM_WORDS = 1024;
  localparam int IDX_W = 10;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int STEP_MS = 200;
  localparam int STEP_CYCLES = STEP_MS * (CLK_HZ / 1000);
  localparam logic [16:0] STEP_MS_INC = 17'(STEP_MS);
  // ----------------------------------------
  // Field-bus float layout: sign, exponent, fraction
  // ----------------------------------------
  localparam int FB_FRAC_W = 15;
  localparam int FB_EXP_W = 8;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    R_NONE = 4'h0, R_PROD = 4'h1, R_CONS = 4'h2, R_CTRL = 4'h3, R_STAT = 4'h4,
    R_REGY = 4'h5, R_SCNL = 4'h6, R_CONF = 4'h7, R_COPY = 4'h8, R_SFR = 4'h9
  } region_t;
  typedef enum logic [1:0] {FB_IDLE = 2'b00, FB_HIGH = 2'b01} fb_state_t;
  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [15:0] data;
  } req_t;
  typedef struct packed {
    logic err;
    logic [15:0] data;
  } rsp_t;
  typedef struct packed {
    logic is_float;
    logic [IDX_W-1:0] index;
    logic [23:0] data;
  } fb_wr_t;
endpackage
`default_nettype wire

// File: fieldbus_adapter_register_map_tb.sv
// Self-checking bench of the adapter register map.
// Assumes the master model and a short timer step for simulation.
`timescale 1ns/10ps
`default_nettype none
module fieldbus_adapter_register_map_tb;
  import fieldbus_adapter_pkg::*;
  localparam int STEP = 8;
  localparam logic [15:0] EDGE_A [21] = '{16'h0000, 16'h0001, 16'h0400, 16'h0401,
    16'h0800, 16'h0801, 16'h0900, 16'h0901, 16'h0C50, 16'h0C51, 16'h1C50, 16'h1C51,
    16'h1D50, 16'h1D51, 16'h1D66, 16'h1E50, 16'h1E51, 16'h2E51, 16'h3E50, 16'h3E51, 16'hFFFF};
  localparam logic [15:0] TMS [4] = '{16'h0001, 16'h00C8, 16'h00C9, 16'h0190};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid, req_ready, rsp_valid, rsp_ready, fb_valid, fb_ready;
  logic act1 = 1'b0;
  logic act2 = 1'b0;
  logic scan1, scan2, lost, lost_q, go, done;
  logic [3:0] stall = 4'h0;
  logic [9:0] cons_addr = 10'h000;
  logic [15:0] cons_data;
  req_t req, cmd;
  rsp_t rsp, got;
  fb_wr_t fb;
  int bad_count = 0;
  int checks = 0;
  int since_take = 0;
  int lost_at = 0;
  always #12.5 clk_i = ~clk_i;
  fieldbus_adapter_regs #(.STEP_CLKS(STEP)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready), .rsp_valid_o(rsp_valid),
    .rsp_o(rsp), .rsp_ready_i(rsp_ready), .fb_valid_i(fb_valid), .fb_i(fb),
    .fb_ready_o(fb_ready), .cons_rd_addr_i(cons_addr), .cons_rd_data_o(cons_data),
    .channel_one_active_i(act1), .channel_two_active_i(act2), .channel_one_scan_o(scan1),
    .channel_two_scan_o(scan2), .link_lost_o(lost));
  modbus_master_model master (.clk_i(clk_i), .go_i(go), .cmd_i(cmd), .stall_i(stall),
    .req_ready_i(req_ready), .rsp_valid_i(rsp_valid), .rsp_i(rsp), .req_valid_o(req_valid),
    .req_o(req), .rsp_ready_o(rsp_ready), .done_o(done), .got_o(got));
  // Cycles from the last take to the rise of the link-loss flag
  always @(posedge clk_i)
  begin
    since_take <= (req_valid && req_ready) ? 0 : since_take + 1;
    lost_q <= lost;
    if (lost && !lost_q)
      lost_at <= since_take;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      input logic [3:0] st);
    int n;
    cmd <= {w, a, d};
    stall <= st;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (!done && n < 100);
    if (n >= 100)
      chk("answer_wait", 0, 1);
  endtask
  task automatic rdchk(input string n, input logic [15:0] a, input logic [15:0] e,
                       input logic [3:0] st);
    xfer(1'b0, a, 16'h0000, st);
    chk(n, {got.err, got.data}, {1'b0, e});
  endtask
  task automatic fbw(input logic fl, input logic [9:0] i, input logic [23:0] d);
    fb_valid <= 1'b1;
    fb <= {fl, i, d};
    do @(posedge clk_i); while (!fb_ready);
    fb_valid <= 1'b0;
    @(posedge clk_i);
  endtask
  // Short field float widened to single precision
  function automatic logic [31:0] ieee(input logic [23:0] v);
    return {v[23], v[22:15], v[14:0], 8'h00};
  endfunction
  // Unmapped numbers and writes to read-only words are refused
  function automatic logic exp_err(input logic w, input logic [15:0] a);
    logic ro;
    ro = a < CONS_BASE || (a >= STAT_BASE && a < REGY_BASE) ||
         (a >= SCNL_BASE && a < COPY_BASE && a != LINK_LOSS_TIMEOUT);
    return a == 16'h0000 || a >= SFR_BASE + SFR_LEN || (w && ro);
  endfunction
  // Watchdog, well beyond the few thousand cycles the run needs
  initial
  begin
    #1000000;
    bad_count++;
    stop_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int unsigned v, x;
    logic [15:0] a;
    logic [31:0] f;
    int k, n, idx;
    go = 1'b0;
    cmd = '0;
    fb_valid = 1'b0;
    fb = '0;
    v = $urandom(32'h81B089F1);
    repeat (3) @(posedge clk_i);
    chk("reset_out", {req_ready, rsp_valid, lost, scan2, scan1}, 5'h10);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    repeat (8)
    begin
      v = $urandom;
      act1 <= v[20];
      act2 <= v[21];
      xfer(1'b1, CHANNEL_ONE_SCAN_CONTROL, v[15:0], 4'h0);
      xfer(1'b1, CHANNEL_TWO_SCAN_CONTROL, v[31:16], 4'h0);
      chk("scan_en", {scan2, scan1}, {v[16], v[0]});
      rdchk("scan_one_rd", CHANNEL_ONE_SCAN_CONTROL, {15'h0, v[20]}, 4'h1);
      rdchk("scan_two_rd", CHANNEL_TWO_SCAN_CONTROL, {15'h0, v[21]}, 4'h0);
      xfer(1'b1, COMBINED_SCAN_CONTROL, v[31:16], 4'h0);
      chk("comb_en", {scan2, scan1}, {v[23], v[16]});
      rdchk("comb_rd", COMBINED_SCAN_CONTROL, {8'h0, v[21], 6'h0, v[20]}, 4'h3);
    end
    for (int i = 0; i < 50; i++)
    begin
      a = (i < 21) ? EDGE_A[i] : 16'($urandom);
      for (k = 0; k < 2; k++)
      begin
        xfer(k[0], a, 16'h0000, 4'($urandom % 8));
        chk("region_err", got.err, exp_err(k[0], a));
      end
    end
    for (k = 0; k < 4; k++)
    begin
      v = $urandom;
      x = $urandom;
      idx = $urandom % 1022;
      f = ieee(v[23:0]);
      fbw(1'b1, 10'(idx), v[23:0]);
      fbw(1'b0, 10'h3FF, x[23:0]);
      xfer(1'b1, PROD_BASE + 16'(idx), ~f[15:0], 4'h0);
      chk("ro_write", got.err, 1'b1);
      rdchk("float_lo", PROD_BASE + 16'(idx), f[15:0], 4'h0);
      rdchk("float_hi", PROD_BASE + 16'(idx + 1), f[31:16], 4'h2);
      rdchk("word", 16'h0400, x[15:0], 4'h0);
      a = CONS_BASE + 16'h0001 + 16'(v % 1023);
      xfer(1'b1, a, x[31:16], 4'h0);
      cons_addr <= 10'(a - CONS_BASE);
      repeat (2) @(posedge clk_i);
      chk("cons_rd", cons_data, x[31:16]);
      rdchk("cons_back", a, x[31:16], 4'h5);
    end
    foreach (TMS[i])
    begin
      xfer(1'b1, COMBINED_SCAN_CONTROL, 16'h0081, 4'h0);
      xfer(1'b1, LINK_LOSS_TIMEOUT, TMS[i], 4'h0);
      n = 0;
      while (!lost && n < 300)
      begin
        @(posedge clk_i);
        n++;
      end
      @(posedge clk_i);
      k = (int'(TMS[i]) + 199) / 200;
      chk("expiry_time", lost_at inside {[k * STEP - 1:k * STEP + 4]}, 1);
      chk("scans_dropped", {lost, scan2, scan1}, 4);
      rdchk("timeout_rd", LINK_LOSS_TIMEOUT, TMS[i], 4'h0);
      xfer(1'b1, 16'h0500, 16'hFFFF, 4'h0);
      chk("scan_stays_off", {scan2, scan1}, 0);
      xfer(1'b1, LINK_LOSS_TIMEOUT, 16'h0000, 4'h0);
      xfer(1'b1, CHANNEL_ONE_SCAN_CONTROL, 16'h0001, 4'h0);
      xfer(1'b1, CHANNEL_TWO_SCAN_CONTROL, 16'h0001, 4'h0);
      chk("scan_rewrite", {scan2, scan1}, 3);
    end
    xfer(1'b1, COMBINED_SCAN_CONTROL, 16'h0081, 4'h0);
    xfer(1'b1, LINK_LOSS_TIMEOUT, 16'd1000, 4'h0);
    // Consumption traffic faster than the timeout keeps the link alive
    repeat (12)
    begin
      v = $urandom;
      xfer(1'b1, CONS_BASE + 16'h0001 + 16'(v % 1023), v[31:16], 4'(v % 3));
      chk("kept_alive", {lost, scan2, scan1}, 3);
    end
    repeat (60) @(posedge clk_i);
    chk("expired", {lost, scan2, scan1}, 4);
    xfer(1'b1, LINK_LOSS_TIMEOUT, 16'h0000, 4'h0);
    xfer(1'b1, COMBINED_SCAN_CONTROL, 16'h0081, 4'h0);
    repeat (100) @(posedge clk_i);
    chk("disabled", {lost, scan2, scan1}, 3);
    stop_test();
  end
endmodule
`default_nettype wire

// File: fieldbus_adapter_regs.sv
// Register map of the field-bus adapter seen from the fieldbus master side.
// Assumes requests by register number on the same clock as the scanners.
// Function
// - One register port exposes both channels' device data to the master.
// - Each device parameter is one word, a float two; parameters sit in adjacent words.
// - Every register is a read/write holding word unless marked otherwise.
// - A 32-bit float takes two consecutive registers.
// - Field 24-bit floats become IEEE single: sign 31, exponent, 23 fraction.
// - First register holds bytes 1,0; second holds bytes 3,2.
// - Any message to registers 1025..2048 restarts the link-loss timer.
// - Timer expiry disables scanning on both channels.
// - Timeout zero disables the timer; otherwise it counts 200 ms steps.
// - A timeout off the 200 ms grid rounds up to the next step.
// - After expiry scanning stays off until the master rewrites scan bits.
// - Timeout is one read/write register at 7526, in milliseconds.
// - Production 1..1024 read-only; consumption 1025..2048 read/write.
// - Control 2049 spans 256 read/write; status 2305 spans 848 read-only.
// - Registry, copy and special regions read/write; scan list and configuration read-only except the timeout.
// - Register 2049 bit 0 scans channel one; 2050 bit 0 channel two.
// - Scan bit one keeps the channel scanning and its devices online.
// - Scan bit zero stops the channel scan, devices take loss action.
// - Register 1025 bit 0 scans channel one, bit 7 channel two.
// - Reading a scan register returns the real scanner state.
`timescale 1ns/10ps
`default_nettype none
module fieldbus_adapter_regs
  import fieldbus_adapter_pkg::*;
#(
  parameter int STEP_CLKS = fieldbus_adapter_pkg::STEP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire fieldbus_adapter_pkg::req_t req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output fieldbus_adapter_pkg::rsp_t rsp_o,
  input wire logic rsp_ready_i,
  input wire logic fb_valid_i,
  input wire fieldbus_adapter_pkg::fb_wr_t fb_i,
  output logic fb_ready_o,
  input wire logic [fieldbus_adapter_pkg::IDX_W-1:0] cons_rd_addr_i,
  output logic [15:0] cons_rd_data_o,
  input wire logic channel_one_active_i,
  input wire logic channel_two_active_i,
  output logic channel_one_scan_o,
  output logic channel_two_scan_o,
  output logic link_lost_o
);
  import fieldbus_adapter_pkg::*;

  localparam int TW = $clog2(STEP_CLKS + 1);

  if (STEP_CLKS < 1)
  begin : g_chk
    $error("STEP_CLKS must be at least one cycle");
  end

  typedef struct packed {
    logic pend;
    req_t preq;
    region_t preg;
    logic ready;
    logic one;
    logic two;
    logic [15:0] tmo;
    logic [TW-1:0] tick;
    logic [16:0] ms;
    logic expired;
    fb_state_t fst;
    logic [IDX_W-1:0] fb_idx;
    logic [15:0] fb_hi;
    logic fb_ready;
  } st_t;

  st_t st_r;
  st_t st_nxt;
  logic [15:0] prod_mem [MEM_WORDS];
  logic [15:0] cons_mem [MEM_WORDS];
  logic [15:0] prod_q_r;
  logic [15:0] cons_q_r;
  logic [15:0] cons_rd_r;
  logic acc;
  logic wr_ok;
  logic restart;
  logic hit;
  logic scan_wr;
  logic pwe;
  logic [IDX_W-1:0] pidx;
  logic [15:0] pdat;
  logic [31:0] fb_f32;
  logic [15:0] off_p;
  logic [15:0] off_c;
  rsp_t ans;
  logic buf_ready;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] b,
                                  input logic [15:0] l);
    logic [15:0] d;
    d = a - b;
    return (a >= b) && (d < l);
  endfunction

  // Region lookup of a register number
  function automatic region_t region_of(input logic [15:0] a);
    region_t r;
    r = R_NONE;
    if (in_rng(a, PROD_BASE, PROD_LEN)) r = R_PROD;
    else if (in_rng(a, CONS_BASE, CONS_LEN)) r = R_CONS;
    else if (in_rng(a, CTRL_BASE, CTRL_LEN)) r = R_CTRL;
    else if (in_rng(a, STAT_BASE, STAT_LEN)) r = R_STAT;
    else if (in_rng(a, REGY_BASE, REGY_LEN)) r = R_REGY;
    else if (in_rng(a, SCNL_BASE, SCNL_LEN)) r = R_SCNL;
    else if (in_rng(a, CONF_BASE, CONF_LEN)) r = R_CONF;
    else if (in_rng(a, COPY_BASE, COPY_LEN)) r = R_COPY;
    else if (in_rng(a, SFR_BASE, SFR_LEN)) r = R_SFR;
    return r;
  endfunction

  // Writable words: read/write regions plus the timeout word
  function automatic logic writable(input logic [15:0] a);
    region_t r;
    r = region_of(a);
    return (r == R_CONS) || (r == R_CTRL) || (r == R_REGY) || (r == R_COPY) ||
           (r == R_SFR) || (a == LINK_LOSS_TIMEOUT);
  endfunction

  // Widen a field float: exponent kept, fraction padded with zeros
  function automatic logic [31:0] f24_to_f32(input logic [23:0] d);
    return {d[23], d[22 -: FB_EXP_W], d[FB_FRAC_W-1:0], 8'h00};
  endfunction

  assign fb_f32 = f24_to_f32(fb_i.data);
  assign off_p = req_i.addr - PROD_BASE;
  assign off_c = req_i.addr - CONS_BASE;

  // ----------------------------------------
  // Next state of the whole block
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    acc = req_valid_i && st_r.ready;
    wr_ok = acc && req_i.write && writable(req_i.addr);
    restart = acc && (region_of(req_i.addr) == R_CONS);
    scan_wr = wr_ok && ((req_i.addr == COMBINED_SCAN_CONTROL) ||
              (req_i.addr == CHANNEL_ONE_SCAN_CONTROL) ||
              (req_i.addr == CHANNEL_TWO_SCAN_CONTROL));
    // Stepped count compared to the raw value, so the grid rounds up
    hit = (st_r.tmo != '0) && !st_r.expired && (st_r.ms >= {1'b0, st_r.tmo});
    pwe = 1'b0;
    pidx = st_r.fb_idx;
    pdat = st_r.fb_hi;

    // Answer of the pending request
    ans = '0;
    if (!st_r.preq.write)
    begin
      case (st_r.preg)
        R_PROD: ans.data = prod_q_r;
        R_CONS:
        begin
          if (st_r.preq.addr == COMBINED_SCAN_CONTROL)
          begin
            ans.data[COMB_ONE_BIT] = channel_one_active_i;
            ans.data[COMB_TWO_BIT] = channel_two_active_i;
          end
          else
          begin
            ans.data = cons_q_r;
          end
        end
        R_CTRL:
        begin
          if (st_r.preq.addr == CHANNEL_ONE_SCAN_CONTROL)
            ans.data[CHAN_SCAN_BIT] = channel_one_active_i;
          else if (st_r.preq.addr == CHANNEL_TWO_SCAN_CONTROL)
            ans.data[CHAN_SCAN_BIT] = channel_two_active_i;
        end
        R_CONF:
        begin
          if (st_r.preq.addr == LINK_LOSS_TIMEOUT)
            ans.data = st_r.tmo;
        end
        default: ans.data = '0;
      endcase
    end
    // Unmapped words and writes to read-only words are refused
    ans.err = (st_r.preg == R_NONE) ||
              (st_r.preq.write && !writable(st_r.preq.addr));
    if (ans.err)
      ans.data = '0;

    // One request in flight; it leaves once the buffer takes it
    if (acc)
    begin
      st_nxt.pend = 1'b1;
      st_nxt.preq = req_i;
      st_nxt.preg = region_of(req_i.addr);
    end
    else if (st_r.pend && buf_ready)
    begin
      st_nxt.pend = 1'b0;
    end
    st_nxt.ready = !st_nxt.pend;

    // Register writes; reserved scan bits are simply not stored
    if (wr_ok)
    begin
      case (req_i.addr)
        COMBINED_SCAN_CONTROL:
        begin
          st_nxt.one = req_i.data[COMB_ONE_BIT];
          st_nxt.two = req_i.data[COMB_TWO_BIT];
        end
        CHANNEL_ONE_SCAN_CONTROL: st_nxt.one = req_i.data[CHAN_SCAN_BIT];
        CHANNEL_TWO_SCAN_CONTROL: st_nxt.two = req_i.data[CHAN_SCAN_BIT];
        LINK_LOSS_TIMEOUT: st_nxt.tmo = req_i.data;
        default: st_nxt.tmo = st_r.tmo;
      endcase
    end

    // Link-loss timer in 200 ms steps, idle when the value is zero
    if (restart || (wr_ok && (req_i.addr == LINK_LOSS_TIMEOUT)))
    begin
      st_nxt.tick = '0;
      st_nxt.ms = '0;
      st_nxt.expired = 1'b0;
    end
    else if ((st_r.tmo != '0) && !st_r.expired)
    begin
      if (st_r.tick == TW'(STEP_CLKS - 1))
      begin
        st_nxt.tick = '0;
        st_nxt.ms = st_r.ms + STEP_MS_INC;
      end
      else
      begin
        st_nxt.tick = st_r.tick + TW'(1);
      end
    end
    // Expiry wins over a scan write in the same cycle
    if (hit)
    begin
      st_nxt.expired = 1'b1;
      st_nxt.one = 1'b0;
      st_nxt.two = 1'b0;
    end

    // Field side: a float fills two production words in two cycles
    case (st_r.fst)
      FB_IDLE:
      begin
        if (fb_valid_i && st_r.fb_ready)
        begin
          pwe = 1'b1;
          pidx = fb_i.index;
          if (fb_i.is_float)
          begin
            pdat = fb_f32[15:0];
            st_nxt.fb_idx = fb_i.index + IDX_W'(1);
            st_nxt.fb_hi = fb_f32[31:16];
            st_nxt.fst = FB_HIGH;
            st_nxt.fb_ready = 1'b0;
          end
          else
          begin
            pdat = fb_i.data[15:0];
          end
        end
      end
      FB_HIGH:
      begin
        pwe = 1'b1;
        st_nxt.fst = FB_IDLE;
        st_nxt.fb_ready = 1'b1;
      end
      default:
      begin
        st_nxt.fst = FB_IDLE;
        st_nxt.fb_ready = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= '{pend: 1'b0, preq: '0, preg: R_NONE, ready: 1'b1, one: SCAN_RST,
                two: SCAN_RST, tmo: TIMEOUT_RST, tick: '0, ms: '0, expired: 1'b0,
                fst: FB_IDLE, fb_idx: '0, fb_hi: '0, fb_ready: 1'b1};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Data arrays; read data is held for the pending answer
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (pwe)
      prod_mem[pidx] <= pdat;
    if (wr_ok && (region_of(req_i.addr) == R_CONS))
      cons_mem[off_c[IDX_W-1:0]] <= req_i.data;
    if (!rst_n_i)
    begin
      prod_q_r <= '0;
      cons_q_r <= '0;
      cons_rd_r <= '0;
    end
    else
    begin
      if (acc)
      begin
        prod_q_r <= prod_mem[off_p[IDX_W-1:0]];
        cons_q_r <= cons_mem[off_c[IDX_W-1:0]];
      end
      cons_rd_r <= cons_mem[cons_rd_addr_i];
    end
  end

  // ----------------------------------------
  // Answer buffer: a stalled master loses no answer
  // ----------------------------------------
  rsp_buffer #(
    .W($bits(rsp_t)),
    .DEPTH(2)
  ) u_rsp (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(st_r.pend),
    .in_data_i(ans),
    .in_ready_o(buf_ready),
    .out_valid_o(rsp_valid_o),
    .out_data_o(rsp_o),
    .out_ready_i(rsp_ready_i)
  );

  assign req_ready_o = st_r.ready;
  assign fb_ready_o = st_r.fb_ready;
  assign cons_rd_data_o = cons_rd_r;
  assign channel_one_scan_o = st_r.one;
  assign channel_two_scan_o = st_r.two;
  assign link_lost_o = st_r.expired;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_float_low;
    fb_valid_i && fb_ready_o && fb_i.is_float && pwe && (pdat == fb_f32[15:0]);
  endsequence
  sequence s_float_high;
    pwe && !fb_ready_o && (pdat == $past(fb_f32[31:16])) &&
    (pidx == $past(fb_i.index) + IDX_W'(1));
  endsequence

  a_timer_restart: assert property (restart |=> (st_r.ms == '0) && (st_r.tick == '0))
    else $error("timer not restarted by consumption message");
  a_expiry_stops: assert property (hit |=> !channel_one_scan_o && !channel_two_scan_o
    && link_lost_o)
    else $error("expiry did not stop both scans");
  a_zero_disables: assert property ((st_r.tmo == '0) && !link_lost_o |=> !link_lost_o)
    else $error("timer expired while disabled");
  a_round_up: assert property ($rose(link_lost_o) |->
    ($past(st_r.ms) >= {1'b0, $past(st_r.tmo)}) &&
    ($past(st_r.ms) < {1'b0, $past(st_r.tmo)} + STEP_MS_INC))
    else $error("expiry not at first step at or above timeout");
  a_scan_hold: assert property (link_lost_o && !channel_one_scan_o && !scan_wr
    |=> !channel_one_scan_o)
    else $error("scan resumed without a scan write");
  a_chan_write: assert property (acc && req_i.write && !hit &&
    (req_i.addr == CHANNEL_ONE_SCAN_CONTROL)
    |=> channel_one_scan_o == $past(req_i.data[CHAN_SCAN_BIT]))
    else $error("channel one scan bit not taken");
  a_comb_write: assert property (acc && req_i.write && !hit &&
    (req_i.addr == COMBINED_SCAN_CONTROL)
    |=> (channel_one_scan_o == $past(req_i.data[COMB_ONE_BIT])) &&
        (channel_two_scan_o == $past(req_i.data[COMB_TWO_BIT])))
    else $error("combined scan bits not taken");
  a_float_order: assert property (s_float_low |=> s_float_high)
    else $error("float words out of order");
  a_prod_readonly: assert property (st_r.pend && st_r.preq.write &&
    (st_r.preg == R_PROD) |-> ans.err)
    else $error("write to production data not refused");
  a_rsvd_zero: assert property (st_r.pend && (st_r.preg == R_CTRL)
    |-> ans.data[15:1] == '0)
    else $error("reserved scan bits not zero");
endmodule
`default_nettype wire

// File: modbus_master_model.sv
// Master model for the adapter register port: one request in flight.
// Assumes the take and answer handshakes of the register port.
`timescale 1ns/10ps
`default_nettype none
module modbus_master_model
  import fieldbus_adapter_pkg::*;
(
  input wire logic clk_i,
  input wire logic go_i,
  input wire fieldbus_adapter_pkg::req_t cmd_i,
  input wire logic [3:0] stall_i,
  input wire logic req_ready_i,
  input wire logic rsp_valid_i,
  input wire fieldbus_adapter_pkg::rsp_t rsp_i,
  output var logic req_valid_o,
  output var fieldbus_adapter_pkg::req_t req_o,
  output var logic rsp_ready_o,
  output var logic done_o,
  output var fieldbus_adapter_pkg::rsp_t got_o
);
  initial
  begin
    req_valid_o = 1'b0;
    req_o = '0;
    rsp_ready_o = 1'b0;
    done_o = 1'b0;
    got_o = '0;
  end
  // Request held until taken; released fields show the inverse
  always
  begin
    @(posedge clk_i);
    done_o <= 1'b0;
    if (go_i)
    begin
      req_valid_o <= 1'b1;
      req_o <= cmd_i;
      do @(posedge clk_i); while (!req_ready_i);
      req_valid_o <= 1'b0;
      req_o <= ~cmd_i;
      // A slow master lets the answer wait in the buffer
      repeat (stall_i) @(posedge clk_i);
      rsp_ready_o <= 1'b1;
      do @(posedge clk_i); while (!(rsp_valid_i && rsp_ready_o));
      got_o <= rsp_i;
      rsp_ready_o <= 1'b0;
      done_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: rsp_buffer.sv
// Small shift buffer with valid and ready on both sides.
// Assumes one clock; the head entry is always slot 0.
`timescale 1ns/10ps
`default_nettype none
module rsp_buffer #(
  parameter int W = 17,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] slot;
    logic [CW-1:0] cnt;
    logic full;
    logic empty;
  } buf_t;
  buf_t st_r;
  buf_t st_nxt;
  logic push;
  logic pop;
  logic [CW-1:0] widx;

  if (DEPTH < 2 || W < 1)
  begin : g_chk
    $error("rsp_buffer needs DEPTH of at least 2");
  end

  // ----------------------------------------
  // Next state: shift on pop so outputs stay flops
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    push = in_valid_i && !st_r.full;
    pop = out_ready_i && !st_r.empty;
    widx = pop ? st_r.cnt - CW'(1) : st_r.cnt;
    if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        st_nxt.slot[i] = st_r.slot[i + 1];
      end
    end
    if (push)
    begin
      st_nxt.slot[widx] = in_data_i;
    end
    st_nxt.cnt = st_r.cnt + CW'(push) - CW'(pop);
    st_nxt.full = st_nxt.cnt == CW'(DEPTH);
    st_nxt.empty = st_nxt.cnt == '0;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= '{slot: '0, cnt: '0, full: 1'b0, empty: 1'b1};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign in_ready_o = !st_r.full;
  assign out_valid_o = !st_r.empty;
  assign out_data_o = st_r.slot[0];
endmodule
`default_nettype wire
